// ===== hdl/wakeq_params.svh
/*
 Constants for the wakeup activity qualifier: register offsets, bit positions,
 reset values and qualification times. Assumes a 250 MHz ref_clk.
*/
// Functional notes
// - network activity needs amplitude and transitions
// - qualified network activity sets flag, interrupt
// - no-activity output low while network qualified
// - qualified network activity in sleep wakes
// - network wake sets network wakeup source
// - network inactivity uses separate timer
// - network line-state bit follows qualified state
// - each line-state change sets flag, interrupt
// - reading interrupt register clears all flags
// - network line-state change clears network ignore
// - unignored qualified network activity blocks sleep
// - change during sleep clears network ignore
// - powerdown bit disables network detector
// - switch low for activity time sets flag
// - qualified switch in sleep wakes, sets source
// - switch release uses separate inactivity timer
// - switch line-state bit set while qualified low
// - switch input debounced internally
// - switch transition clears ignore; activity holds
`ifndef WAKEQ_PARAMS_SVH
`define WAKEQ_PARAMS_SVH

`define WQ_ADDR_FLAG 8'h00
`define WQ_ADDR_MASK 8'h04
`define WQ_ADDR_LINE 8'h08
`define WQ_ADDR_WSRC 8'h0c
`define WQ_ADDR_IGN 8'h10
`define WQ_ADDR_CFG 8'h14

`define WQ_BIT_NET 0
`define WQ_BIT_SW 1
`define WQ_CFG_PD 0
`define WQ_CFG_SLEEP 1

`define WQ_RST_MASK 2'h0
`define WQ_RST_CFG 1'b0

`define WQ_CLK_MHZ 250
`define WQ_NET_ACT_NS 2000
`define WQ_NET_INACT_NS 4000
`define WQ_SW_ACT_NS 8000
`define WQ_SW_INACT_NS 8000
`define WQ_CYC(ns) (((ns) * `WQ_CLK_MHZ + 999) / 1000)
`define WQ_NET_ACT_CYC `WQ_CYC(`WQ_NET_ACT_NS)
`define WQ_NET_INACT_CYC `WQ_CYC(`WQ_NET_INACT_NS)
`define WQ_SW_ACT_CYC `WQ_CYC(`WQ_SW_ACT_NS)
`define WQ_SW_INACT_CYC `WQ_CYC(`WQ_SW_INACT_NS)

`endif

// ===== hdl/wakeq_pkg.sv
/*
 Types for the wakeup activity qualifier. Assumes wakeq_params.svh for numbers.
*/
package wakeq_pkg;
    typedef enum logic [1:0] {
        WQ_ACTIVE = 2'b01,
        WQ_SLEEP = 2'b10
    } wakeq_mode_type;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } wakeq_bus_req_type;
endpackage

// ===== hdl/wakeq_qualifier.sv
/*
 Activity/inactivity qualification timer for one wake input.
 Assumes active_in is already synchronous and active high.
*/
`timescale 1ns/1ps
`default_nettype none
module wakeq_qualifier (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic active_in,
    input wire logic [15:0] act_cycles,
    input wire logic [15:0] inact_cycles,
    output var logic state_ff,
    output var logic change_ff
);
    logic [15:0] cnt_ff;
    logic [15:0] limit;

    // one shared counter, with a separate limit for each direction
    assign limit = state_ff ? inact_cycles : act_cycles;

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            cnt_ff <= 16'h0000;
            state_ff <= 1'b0;
            change_ff <= 1'b0;
        end else if (active_in == state_ff) begin
            // input back at qualified level: pending event dropped
            cnt_ff <= 16'h0000;
            change_ff <= 1'b0;
        end else if (cnt_ff + 16'h0001 >= limit) begin
            cnt_ff <= 16'h0000;
            state_ff <= active_in;
            change_ff <= 1'b1;
        end else begin
            cnt_ff <= cnt_ff + 16'h0001;
            change_ff <= 1'b0;
        end
    end

    property p_q_timed;
        @(posedge ref_clk) disable iff (sys_rst)
        (state_ff != $past(state_ff)) |-> ($past(cnt_ff) + 16'h0001 >= $past(limit));
    endproperty
    a_q_timed: assert property (p_q_timed) else $error("state flipped early");

    property p_q_level;
        @(posedge ref_clk) disable iff (sys_rst)
        change_ff |-> (state_ff == $past(active_in));
    endproperty
    a_q_level: assert property (p_q_level) else $error("state not input level");
endmodule
`default_nettype wire

// ===== hdl/wakeq_sync.sv
/*
 Two-flop synchroniser for asynchronous wake inputs.
 Assumes a single clock; first stage feeds only the second.
*/
`timescale 1ns/1ps
`default_nettype none
module wakeq_sync #(
    parameter int WIDTH = 3
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [WIDTH-1:0] async_in,
    output var logic [WIDTH-1:0] sync_ff
);
    logic [WIDTH-1:0] meta_ff;

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= async_in;
            sync_ff <= meta_ff;
        end
    end
endmodule
`default_nettype wire

// ===== hdl/wakeq_top.sv
/*
 Wakeup activity qualifier: network detector and local switch inputs,
 qualification, line state, interrupt flags, mask, wakeup source, ignore
 bits and sleep/active mode. Assumes a plain register port with read data
 one cycle after the read strobe, and the analog detector giving amplitude
 and transition indications as logic levels.
*/
// Local design decisions: the address map and strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "wakeq_params.svh"
module wakeq_top
    import wakeq_pkg::*;
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire wakeq_bus_req_type bus_req,
    output var logic [7:0] bus_rdata_ff,
    input wire logic net_amplitude_ok,
    input wire logic net_transitions_ok,
    input wire logic local_switch_input,
    input wire logic protected_supply_ok,
    output var logic int_n_ff,
    output var logic no_activity_indicator_n_ff,
    output var logic active_mode_ff,
    output var logic net_detector_powerdown_ff
);
    localparam logic [15:0] ACT_CYC [2] = '{16'(`WQ_NET_ACT_CYC), 16'(`WQ_SW_ACT_CYC)};
    localparam logic [15:0] INACT_CYC [2] = '{16'(`WQ_NET_INACT_CYC), 16'(`WQ_SW_INACT_CYC)};

    logic [2:0] sync_q;
    logic [1:0] act_in;
    logic [1:0] line_state;
    logic [1:0] change;
    logic [1:0] rise;
    logic [1:0] flag_ff;
    logic [1:0] mask_ff;
    logic [1:0] ign_ff;
    logic [1:0] wsrc_ff;
    logic hold_active;
    logic sleep_req;
    logic wake;
    wakeq_mode_type mode_ff;
    wakeq_mode_type nxt_mode;
    logic [7:0] nxt_rdata;

    function automatic logic hit(input wakeq_bus_req_type r, input logic [7:0] a);
        hit = (r.addr == a);
    endfunction

    wakeq_sync #(
        .WIDTH(3)
    ) u_sync (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        // switch inverted ahead of the sync so its reset value is the idle level
        .async_in({~local_switch_input, net_transitions_ok, net_amplitude_ok}),
        .sync_ff(sync_q)
    );

    // both amplitude and transitions, and nothing while powered down
    assign act_in[`WQ_BIT_NET] = sync_q[0] & sync_q[1] & ~net_detector_powerdown_ff;
    assign act_in[`WQ_BIT_SW] = sync_q[2];

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_qual
            wakeq_qualifier u_qual (
                .ref_clk(ref_clk),
                .sys_rst(sys_rst),
                .active_in(act_in[gi]),
                .act_cycles(ACT_CYC[gi]),
                .inact_cycles(INACT_CYC[gi]),
                .state_ff(line_state[gi]),
                .change_ff(change[gi])
            );
        end
    endgenerate

    assign rise = change & line_state;
    // an ignored input no longer keeps the device awake
    assign hold_active = |(line_state & ~ign_ff);
    assign sleep_req = bus_req.wr & hit(bus_req, `WQ_ADDR_CFG) & bus_req.wdata[`WQ_CFG_SLEEP];
    assign wake = (mode_ff == WQ_SLEEP) & (|rise) & protected_supply_ok;

    always_comb begin
        nxt_mode = mode_ff;
        case (mode_ff)
            WQ_ACTIVE: begin
                if (sleep_req && !hold_active) begin
                    nxt_mode = WQ_SLEEP;
                end
            end
            WQ_SLEEP: begin
                if (wake) begin
                    nxt_mode = WQ_ACTIVE;
                end
            end
            default: nxt_mode = WQ_ACTIVE;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            mode_ff <= WQ_ACTIVE;
            active_mode_ff <= 1'b1;
        end else begin
            mode_ff <= nxt_mode;
            active_mode_ff <= (nxt_mode == WQ_ACTIVE);
        end
    end

    // flags: a set in the same cycle as the clearing read wins
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            flag_ff <= 2'h0;
        end else begin
            flag_ff <= (flag_ff & ~{2{bus_req.rd & hit(bus_req, `WQ_ADDR_FLAG)}})
                       | change;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            int_n_ff <= 1'b1;
        end else begin
            int_n_ff <= ~|(flag_ff & ~mask_ff);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            no_activity_indicator_n_ff <= 1'b1;
        end else begin
            no_activity_indicator_n_ff <= ~line_state[`WQ_BIT_NET];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            mask_ff <= `WQ_RST_MASK;
            net_detector_powerdown_ff <= `WQ_RST_CFG;
        end else if (bus_req.wr) begin
            if (hit(bus_req, `WQ_ADDR_MASK)) begin
                mask_ff <= bus_req.wdata[1:0];
            end
            if (hit(bus_req, `WQ_ADDR_CFG)) begin
                net_detector_powerdown_ff <= bus_req.wdata[`WQ_CFG_PD];
            end
        end
    end

    // ignore bits: any qualified change clears, beating a host write
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            ign_ff <= 2'h0;
        end else if (bus_req.wr && hit(bus_req, `WQ_ADDR_IGN)) begin
            ign_ff <= bus_req.wdata[1:0] & ~change;
        end else begin
            ign_ff <= ign_ff & ~change;
        end
    end

    // wakeup source: write one to clear, new wake wins
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            wsrc_ff <= 2'h0;
        end else begin
            wsrc_ff <= (wsrc_ff & ~({2{bus_req.wr & hit(bus_req, `WQ_ADDR_WSRC)}}
                       & bus_req.wdata[1:0])) | ({2{wake}} & rise);
        end
    end

    always_comb begin
        nxt_rdata = 8'h00;
        if (bus_req.rd) begin
            case (bus_req.addr)
                `WQ_ADDR_FLAG: nxt_rdata = {6'h00, flag_ff};
                `WQ_ADDR_MASK: nxt_rdata = {6'h00, mask_ff};
                `WQ_ADDR_LINE: nxt_rdata = {6'h00, line_state};
                `WQ_ADDR_WSRC: nxt_rdata = {6'h00, wsrc_ff};
                `WQ_ADDR_IGN: nxt_rdata = {6'h00, ign_ff};
                `WQ_ADDR_CFG: nxt_rdata = {7'h00, net_detector_powerdown_ff};
                default: nxt_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            bus_rdata_ff <= 8'h00;
        end else begin
            bus_rdata_ff <= nxt_rdata;
        end
    end

    property p_int_low;
        @(posedge ref_clk) disable iff (sys_rst)
        (change[0] && !mask_ff[0]) |=> ##1 !int_n_ff;
    endproperty
    a_int_low: assert property (p_int_low) else $error("network event missed interrupt");

    property p_no_activity_indicator;
        @(posedge ref_clk) disable iff (sys_rst)
        line_state[0] |=> !no_activity_indicator_n_ff;
    endproperty
    a_no_activity_indicator: assert property (p_no_activity_indicator) else $error("no-activity output not low");

    property p_wake;
        @(posedge ref_clk) disable iff (sys_rst)
        (mode_ff == WQ_SLEEP && rise[0] && protected_supply_ok) |=> active_mode_ff ##0 wsrc_ff[0];
    endproperty
    a_wake: assert property (p_wake) else $error("network wake failed");

    property p_wsrc;
        @(posedge ref_clk) disable iff (sys_rst)
        $rose(wsrc_ff[0]) |-> $past(wake && rise[0]);
    endproperty
    a_wsrc: assert property (p_wsrc) else $error("source bit without wake");

    property p_flag_set;
        @(posedge ref_clk) disable iff (sys_rst)
        |change |=> ((flag_ff & $past(change)) == $past(change));
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("flag not set on change");

    property p_read_clear;
        @(posedge ref_clk) disable iff (sys_rst)
        (bus_req.rd && bus_req.addr == `WQ_ADDR_FLAG && change == 2'h0) |=> flag_ff == 2'h0;
    endproperty
    a_read_clear: assert property (p_read_clear) else $error("read did not clear flags");

    property p_ign_clear;
        @(posedge ref_clk) disable iff (sys_rst)
        change[0] |=> !ign_ff[0];
    endproperty
    a_ign_clear: assert property (p_ign_clear) else $error("ignore not cleared");

    property p_hold;
        @(posedge ref_clk) disable iff (sys_rst)
        (mode_ff == WQ_ACTIVE && line_state[0] && !ign_ff[0]) |=> mode_ff == WQ_ACTIVE;
    endproperty
    a_hold: assert property (p_hold) else $error("slept with active network");

    property p_pd;
        @(posedge ref_clk) disable iff (sys_rst)
        (net_detector_powerdown_ff && !line_state[0]) |=> !line_state[0];
    endproperty
    a_pd: assert property (p_pd) else $error("detector active while powered down");

    property p_int_low_sw;
        @(posedge ref_clk) disable iff (sys_rst)
        (change[1] && !mask_ff[1]) |=> ##1 !int_n_ff;
    endproperty
    a_int_low_sw: assert property (p_int_low_sw) else $error("switch event missed interrupt");

    property p_int_high;
        @(posedge ref_clk) disable iff (sys_rst)
        ((flag_ff & ~mask_ff) == 2'h0) |=> int_n_ff;
    endproperty
    a_int_high: assert property (p_int_high) else $error("interrupt held without flag");

    property p_int_cause;
        @(posedge ref_clk) disable iff (sys_rst)
        !int_n_ff |-> $past(|(flag_ff & ~mask_ff));
    endproperty
    a_int_cause: assert property (p_int_cause) else $error("interrupt without unmasked flag");

    property p_flag_keep;
        @(posedge ref_clk) disable iff (sys_rst)
        !(bus_req.rd && bus_req.addr == `WQ_ADDR_FLAG) |=> ((flag_ff & $past(flag_ff)) == $past(flag_ff));
    endproperty
    a_flag_keep: assert property (p_flag_keep) else $error("flag lost without read");

    property p_flag_cause;
        @(posedge ref_clk) disable iff (sys_rst)
        (flag_ff & ~$past(flag_ff) & ~$past(change)) == 2'h0;
    endproperty
    a_flag_cause: assert property (p_flag_cause) else $error("flag set without change");

    property p_no_activity_indicator_high;
        @(posedge ref_clk) disable iff (sys_rst)
        !line_state[0] |=> no_activity_indicator_n_ff;
    endproperty
    a_no_activity_indicator_high: assert property (p_no_activity_indicator_high) else $error("no-activity low while idle");

    property p_wake_sw;
        @(posedge ref_clk) disable iff (sys_rst)
        (mode_ff == WQ_SLEEP && rise[1] && protected_supply_ok) |=> active_mode_ff ##0 wsrc_ff[1];
    endproperty
    a_wake_sw: assert property (p_wake_sw) else $error("switch wake failed");

    property p_supply_gate;
        @(posedge ref_clk) disable iff (sys_rst)
        (mode_ff == WQ_SLEEP && !protected_supply_ok) |=> mode_ff == WQ_SLEEP;
    endproperty
    a_supply_gate: assert property (p_supply_gate) else $error("woke with bad supply");

    property p_wsrc_sw;
        @(posedge ref_clk) disable iff (sys_rst)
        $rose(wsrc_ff[1]) |-> $past(wake && rise[1]);
    endproperty
    a_wsrc_sw: assert property (p_wsrc_sw) else $error("switch source without wake");

    property p_ign_clear_sw;
        @(posedge ref_clk) disable iff (sys_rst)
        change[1] |=> !ign_ff[1];
    endproperty
    a_ign_clear_sw: assert property (p_ign_clear_sw) else $error("switch ignore not cleared");

    property p_hold_sw;
        @(posedge ref_clk) disable iff (sys_rst)
        (mode_ff == WQ_ACTIVE && line_state[1] && !ign_ff[1]) |=> mode_ff == WQ_ACTIVE;
    endproperty
    a_hold_sw: assert property (p_hold_sw) else $error("slept with active switch");

    property p_mode_out;
        @(posedge ref_clk) disable iff (sys_rst)
        active_mode_ff == (mode_ff == WQ_ACTIVE);
    endproperty
    a_mode_out: assert property (p_mode_out) else $error("mode output disagrees");

    property p_sleep_req;
        @(posedge ref_clk) disable iff (sys_rst)
        (mode_ff == WQ_ACTIVE && !sleep_req) |=> mode_ff == WQ_ACTIVE;
    endproperty
    a_sleep_req: assert property (p_sleep_req) else $error("slept without request");

    property p_line_read;
        @(posedge ref_clk) disable iff (sys_rst)
        (bus_req.rd && bus_req.addr == `WQ_ADDR_LINE) |=> bus_rdata_ff == {6'h00, $past(line_state)};
    endproperty
    a_line_read: assert property (p_line_read) else $error("line state read wrong");

    property p_net_both;
        @(posedge ref_clk) disable iff (sys_rst)
        $rose(line_state[0]) |-> $past(sync_q[0] && sync_q[1] && !net_detector_powerdown_ff);
    endproperty
    a_net_both: assert property (p_net_both) else $error("network qualified on one cue");

    property p_net_inact_hold;
        @(posedge ref_clk) disable iff (sys_rst)
        $rose(line_state[0]) |=> line_state[0] [*8];
    endproperty
    a_net_inact_hold: assert property (p_net_inact_hold) else $error("network fell too soon");

    property p_sw_inact_hold;
        @(posedge ref_clk) disable iff (sys_rst)
        $rose(line_state[1]) |=> line_state[1] [*8];
    endproperty
    a_sw_inact_hold: assert property (p_sw_inact_hold) else $error("switch fell too soon");

    property p_sw_level;
        @(posedge ref_clk) disable iff (sys_rst)
        $rose(line_state[1]) |-> $past(sync_q[2]);
    endproperty
    a_sw_level: assert property (p_sw_level) else $error("switch qualified while high");
endmodule
`default_nettype wire

// ===== test/wakeq_host_model.sv
/*
 Host controller model: plain register-port master for the qualifier.
 Assumes the slave never stalls and read data stand one cycle after rd.
*/
`timescale 1ns/1ps
`default_nettype none
`include "wakeq_params.svh"
module wakeq_host_model
    import wakeq_pkg::*;
(
    input wire logic ref_clk,
    output var wakeq_bus_req_type bus_req,
    input wire logic [7:0] bus_rdata_ff
);
    initial begin
        bus_req = '0;
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        bus_req.addr <= a;
        bus_req.wdata <= d;
        bus_req.wr <= 1'b1;
        @(posedge ref_clk);
        bus_req.wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        bus_req.addr <= a;
        bus_req.rd <= 1'b1;
        @(posedge ref_clk);
        bus_req.rd <= 1'b0;
        // data lands on the taking edge; look once it has settled
        #1;
        d = bus_rdata_ff;
    endtask

    // stuck input: ignore it first, then ask for sleep
    task automatic ignore_and_sleep(input logic [7:0] bits);
        wr(`WQ_ADDR_IGN, bits);
        wr(`WQ_ADDR_CFG, 8'h02);
    endtask
endmodule
`default_nettype wire

// ===== test/wakeq_top_bench.sv
/*
 Self-checking bench for the wakeup activity qualifier.
 Assumes the qualification counts of wakeq_params.svh and a 2-flop sync.
*/
`timescale 1ns/1ps
`default_nettype none
`include "wakeq_params.svh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module wakeq_top_bench
    import wakeq_pkg::*;
;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    wakeq_bus_req_type bus_req;
    logic [7:0] rdata;
    logic int_n, no_activity_indicator_n, act, pd;
    logic amp = 1'b0;
    logic trn = 1'b0;
    logic sw = 1'b1;
    logic sup = 1'b1;
    int n_checks = 0;
    int n_mismatch = 0;

    wakeq_top u_wakeq_top (.ref_clk(ref_clk), .sys_rst(sys_rst), .bus_req(bus_req),
        .bus_rdata_ff(rdata), .net_amplitude_ok(amp), .net_transitions_ok(trn),
        .local_switch_input(sw), .protected_supply_ok(sup), .int_n_ff(int_n),
        .no_activity_indicator_n_ff(no_activity_indicator_n), .active_mode_ff(act),
        .net_detector_powerdown_ff(pd));
    wakeq_host_model u_wakeq_host_model (.ref_clk(ref_clk), .bus_req(bus_req),
        .bus_rdata_ff(rdata));

    initial begin
        forever #2 ref_clk = ~ref_clk;
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [7:0] e, input string nm);
        logic [7:0] d;
        u_wakeq_host_model.rd(a, d);
        `CHK(nm, e, d)
    endtask

    task automatic t_reset;
        `CHK("int_n", 1'b1, int_n)
        `CHK("active", 1'b1, act)
        `CHK("no_activity_indicator_n", 1'b1, no_activity_indicator_n)
        `CHK("powerdown", 1'b0, pd)
        rchk(`WQ_ADDR_MASK, 8'h00, "mask");
        rchk(`WQ_ADDR_CFG, 8'h00, "cfg");
        rchk(`WQ_ADDR_FLAG, 8'h00, "flag");
        rchk(8'h20, 8'h00, "unmapped");
    endtask

    task automatic t_net;
        @(posedge ref_clk) amp <= 1'b1;
        cyc(700);
        rchk(`WQ_ADDR_LINE, 8'h00, "amp only line");
        @(posedge ref_clk) trn <= 1'b1;
        cyc(300);
        `CHK("int_n early", 1'b1, int_n)
        cyc(220);
        `CHK("no_activity_indicator_n", 1'b0, no_activity_indicator_n)
        `CHK("int_n", 1'b0, int_n)
        rchk(`WQ_ADDR_LINE, 8'h01, "line");
        rchk(`WQ_ADDR_FLAG, 8'h01, "flag");
        rchk(`WQ_ADDR_FLAG, 8'h00, "flag cleared");
        // int_n rises one cycle after the clearing read
        `CHK("int_n read", 1'b1, int_n)
        @(posedge ref_clk) amp <= 1'b0;
        cyc(900);
        rchk(`WQ_ADDR_LINE, 8'h01, "line hold");
        cyc(120);
        rchk(`WQ_ADDR_LINE, 8'h00, "line fall");
        `CHK("no_activity_indicator_n off", 1'b1, no_activity_indicator_n)
        `CHK("int_n fall", 1'b0, int_n)
        rchk(`WQ_ADDR_FLAG, 8'h01, "flag fall");
    endtask

    task automatic t_switch;
        @(posedge ref_clk) sw <= 1'b0;
        cyc(1500);
        @(posedge ref_clk) sw <= 1'b1;
        cyc(2100);
        rchk(`WQ_ADDR_LINE, 8'h00, "sw glitch");
        `CHK("int_n glitch", 1'b1, int_n)
        u_wakeq_host_model.wr(`WQ_ADDR_MASK, 8'h02);
        @(posedge ref_clk) sw <= 1'b0;
        cyc(2100);
        rchk(`WQ_ADDR_LINE, 8'h02, "sw line");
        `CHK("int_n masked", 1'b1, int_n)
        rchk(`WQ_ADDR_FLAG, 8'h02, "sw flag");
        u_wakeq_host_model.wr(`WQ_ADDR_MASK, 8'h00);
        @(posedge ref_clk) sw <= 1'b1;
        cyc(1000);
        @(posedge ref_clk) sw <= 1'b0;
        cyc(2100);
        rchk(`WQ_ADDR_LINE, 8'h02, "sw bounce");
    endtask

    task automatic t_sw_sleep;
        u_wakeq_host_model.wr(`WQ_ADDR_CFG, 8'h02);
        cyc(4);
        `CHK("sw holds active", 1'b1, act)
        u_wakeq_host_model.ignore_and_sleep(8'h02);
        cyc(4);
        `CHK("sw ignored sleep", 1'b0, act)
        @(posedge ref_clk) sw <= 1'b1;
        cyc(2100);
        rchk(`WQ_ADDR_IGN, 8'h00, "sw ignore cleared");
        rchk(`WQ_ADDR_FLAG, 8'h02, "sw fall flag");
        @(posedge ref_clk) sw <= 1'b0;
        cyc(2100);
        `CHK("sw wake", 1'b1, act)
        rchk(`WQ_ADDR_WSRC, 8'h02, "sw source");
        u_wakeq_host_model.wr(`WQ_ADDR_WSRC, 8'h02);
        rchk(`WQ_ADDR_WSRC, 8'h00, "source cleared");
        @(posedge ref_clk) sw <= 1'b1;
        cyc(2100);
        rchk(`WQ_ADDR_FLAG, 8'h02, "sw release flag");
    endtask

    task automatic t_net_sleep;
        @(posedge ref_clk) amp <= 1'b1;
        cyc(520);
        u_wakeq_host_model.wr(`WQ_ADDR_CFG, 8'h02);
        cyc(4);
        `CHK("net holds active", 1'b1, act)
        u_wakeq_host_model.ignore_and_sleep(8'h01);
        cyc(4);
        `CHK("net ignored sleep", 1'b0, act)
        @(posedge ref_clk) amp <= 1'b0;
        cyc(1020);
        rchk(`WQ_ADDR_IGN, 8'h00, "net ignore cleared");
        `CHK("still asleep", 1'b0, act)
        @(posedge ref_clk) begin
            sup <= 1'b0;
            amp <= 1'b1;
        end
        cyc(520);
        `CHK("low supply asleep", 1'b0, act)
        rchk(`WQ_ADDR_WSRC, 8'h00, "low supply source");
        @(posedge ref_clk) begin
            sup <= 1'b1;
            amp <= 1'b0;
        end
        cyc(1020);
        @(posedge ref_clk) amp <= 1'b1;
        cyc(520);
        `CHK("net wake", 1'b1, act)
        rchk(`WQ_ADDR_WSRC, 8'h01, "net source");
        u_wakeq_host_model.wr(`WQ_ADDR_WSRC, 8'h01);
        // powerdown drops the detector: its qualified fall follows
        u_wakeq_host_model.wr(`WQ_ADDR_CFG, 8'h01);
        cyc(2);
        `CHK("powerdown", 1'b1, pd)
        rchk(`WQ_ADDR_CFG, 8'h01, "cfg pd");
        cyc(1020);
        rchk(`WQ_ADDR_LINE, 8'h00, "pd line");
        `CHK("pd no_activity_indicator_n", 1'b1, no_activity_indicator_n)
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        // whole run is some 22k cycles; allow well over that
        #200000;
        n_mismatch++;
        results();
    end

    initial begin
        repeat (4) @(posedge ref_clk);
        sys_rst <= 1'b0;
        cyc(3);
        t_reset();
        t_net();
        t_switch();
        t_sw_sleep();
        t_net_sleep();
        results();
    end
endmodule
`default_nettype wire
